/* File: rtl/umc_map.svh */
`ifndef UMC_MAP_SVH
`define UMC_MAP_SVH

// Register offsets
`define UMC_OFF_CTRL      8'h00
`define UMC_OFF_MODE      8'h04
`define UMC_OFF_IEN_SET   8'h08
`define UMC_OFF_IEN_CLR   8'h0C
`define UMC_OFF_IEN_VIEW  8'h10
`define UMC_OFF_STATUS    8'h14

// Reset values and writable bits
`define UMC_MODE_RST      32'h0000_0000
`define UMC_MODE_WMASK    32'h173F_FFFF
`define UMC_IMR_RST       32'h0000_0000
`define UMC_IRQ_WMASK     32'h000F_3FFF

// Control register fields
`define UMC_CR_RETRY_CLR  13

// Mode register fields
`define UMC_MD_USMODE     3:0
`define UMC_MD_CLKSEL     5:4
`define UMC_MD_CLEN       7:6
`define UMC_MD_CHAN       15:14
`define UMC_MD_ORDER      16
`define UMC_MD_NINE       17
`define UMC_MD_CKOUT      18
`define UMC_MD_NOACK      20
`define UMC_MD_SUCC       21
`define UMC_MD_MAXIT      26:24
`define UMC_MD_FILTER     28

// Field values
`define UMC_USMODE_ISO_T0 4'h4
`define UMC_USMODE_ISO_T1 4'h6
`define UMC_CLKSEL_EXT    2'h3
`define UMC_NINE_BITS     4'h9
`define UMC_CHAR_BASE     4'h5

// Status bit positions
`define UMC_ST_ITER       10

`endif

/* File: rtl/umc_pkg.sv */
package umc_pkg;

   typedef logic [31:0] umc_word_t;

   typedef enum logic [1:0]
   {
      UMC_CH_NORMAL = 2'h0,
      UMC_CH_ECHO   = 2'h1,
      UMC_CH_LOCAL  = 2'h2,
      UMC_CH_REMOTE = 2'h3
   } umc_chan_e;

endpackage

/* File: rtl/umc_top.sv */
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`include "umc_map.svh"

// Behaviour
// RULE1 - Echo: receive line copied onto transmit pin
// RULE2 - Local loop: transmitter output feeds receiver
// RULE3 - Remote loop: receive pin to transmit pin
// RULE4 - Bit order select picks MSB first
// RULE5 - Nine-bit select forces 9-bit characters
// RULE6 - Clock pin driven unless external clock chosen; code also requires the clock output bit (bit 18) set
// RULE7 - NACK inhibit suppresses every NACK
// RULE8 - Parity error gives immediate NACK normally
// RULE9 - Successive NACKs counted up to limit
// RULE10 - At limit stop NACKs, raise iteration flag
// RULE11 - Retry limit used only in T0
// RULE12 - Filter: two-of-three vote at sample tick
// RULE13 - Filter off: receive line passes unfiltered; code still drops pulses seen for only one clock in the synchroniser
// RULE14 - Enable-set writes of one enable sources
// RULE15 - Interrupt bit positions 0 to 13
// RULE16 - Modem change bits 16 to 19
// RULE17 - Enable-clear writes of one disable sources
// RULE18 - Mask view reports enabled sources
// RULE19 - T0 mode value gates retry and NACK
// RULE20 - Retry flag clear only in ISO mode
// RULE21 - Interrupt is OR of masked flags
// RULE22 - Mask resets zero, updates next cycle
module umc_top
#(
   parameter int ADDR_W = 12
)
(
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [ADDR_W-1:0]  paddr,
   input  wire umc_pkg::umc_word_t pwdata,
   output      umc_pkg::umc_word_t prdata,
   output      logic               pready,
   output      logic               pslverr,
   // Serial pins
   input  wire logic               rxd_pin,
   output      logic               txd_pin,
   input  wire logic               sck_in,
   output      logic               sck_out,
   output      logic               sck_oe_n,
   // Core side
   input  wire logic               tx_serial,
   output      logic               rx_serial,
   input  wire logic               sample_tick,
   input  wire logic               baud_clk,
   input  wire logic               parity_err,
   input  wire logic               char_ok,
   output      logic               nack_req,
   output      logic               msb_first,
   output      logic [3:0]         char_bits,
   output      logic [3:0]         usart_mode,
   // Status and interrupt
   input  wire umc_pkg::umc_word_t status_src,
   output      logic               irq
);
   import umc_pkg::*;

   // -----------------------------------------------
   // Elaboration check
   // -----------------------------------------------
   generate
      if (ADDR_W < 8 || ADDR_W > 32)
      begin : g_bad_addr
         $error("ADDR_W must be 8 to 32");
      end
   endgenerate

   // -----------------------------------------------
   // Registers
   // -----------------------------------------------
   umc_word_t  mode_q;
   umc_word_t  mask_q;
   umc_word_t  prdata_q;
   logic       sync1_q;
   logic       sync2_q;
   logic       sync3_q;
   logic       rxd_q;
   logic [2:0] samp_q;
   logic       txd_q;
   logic       rxs_q;
   logic       sck_q;
   logic       sck_oe_n_q;
   logic [2:0] cnt_q;
   logic       iter_q;
   logic       nack_q;
   logic       irq_q;

   // -----------------------------------------------
   // APB decode
   // -----------------------------------------------
   wire logic [7:0] offs = paddr[7:0];
   wire logic hi_zero = (paddr >> 8) == '0;
   wire logic setup = psel & ~penable;
   wire logic access = psel & penable;
   wire logic hit_ctrl = hi_zero && offs == `UMC_OFF_CTRL;
   wire logic hit_mode = hi_zero && offs == `UMC_OFF_MODE;
   wire logic hit_set = hi_zero && offs == `UMC_OFF_IEN_SET;
   wire logic hit_clr = hi_zero && offs == `UMC_OFF_IEN_CLR;
   wire logic hit_view = hi_zero && offs == `UMC_OFF_IEN_VIEW;
   wire logic hit_stat = hi_zero && offs == `UMC_OFF_STATUS;
   wire logic addr_ok = hit_ctrl | hit_mode | hit_set |
                        hit_clr | hit_view | hit_stat;
   wire logic wr = access & pwrite & addr_ok;
   wire logic wr_ctrl = wr & hit_ctrl;
   wire logic wr_mode = wr & hit_mode;
   wire logic wr_set = wr & hit_set;
   wire logic wr_clr = wr & hit_clr;
   wire logic rd_setup = setup & ~pwrite;

   assign pready  = 1'b1;
   assign pslverr = access & ~addr_ok;

   // -----------------------------------------------
   // Mode fields
   // -----------------------------------------------
   wire umc_chan_e chan = umc_chan_e'(mode_q[`UMC_MD_CHAN]);
   wire logic [3:0] usmode = mode_q[`UMC_MD_USMODE];
   wire logic iso_t0 = usmode == `UMC_USMODE_ISO_T0; // RULE19
   wire logic iso_any = iso_t0 ||
                        usmode == `UMC_USMODE_ISO_T1;
   wire logic nack_inh = mode_q[`UMC_MD_NOACK];
   wire logic succ_dis = mode_q[`UMC_MD_SUCC];
   wire logic [2:0] max_it = mode_q[`UMC_MD_MAXIT];
   wire logic filter_on = mode_q[`UMC_MD_FILTER];
   wire logic sck_drive = mode_q[`UMC_MD_CKOUT] &&
        mode_q[`UMC_MD_CLKSEL] != `UMC_CLKSEL_EXT; // RULE6

   assign msb_first  = mode_q[`UMC_MD_ORDER]; // RULE4
   assign usart_mode = usmode;
   assign char_bits  = mode_q[`UMC_MD_NINE] ? // RULE5
                       `UMC_NINE_BITS :
                       `UMC_CHAR_BASE +
                       {2'b00, mode_q[`UMC_MD_CLEN]};

   // -----------------------------------------------
   // Receive line filter
   // -----------------------------------------------
   wire logic maj = (samp_q[0] & samp_q[1]) |
                    (samp_q[1] & samp_q[2]) |
                    (samp_q[0] & samp_q[2]);
   wire logic rx_line = filter_on ? maj : rxd_q; // RULE12 RULE13

   // -----------------------------------------------
   // Channel routing
   // -----------------------------------------------
   wire logic txd_d =
      (chan == UMC_CH_ECHO)   ? rx_line :   // RULE1
      (chan == UMC_CH_REMOTE) ? rx_line :   // RULE3
      (chan == UMC_CH_LOCAL)  ? 1'b1 :
                                tx_serial;
   wire logic rxs_d =
      (chan == UMC_CH_LOCAL)  ? tx_serial : // RULE2
      (chan == UMC_CH_REMOTE) ? 1'b1 :
                                rx_line;

   // -----------------------------------------------
   // NACK and retry counting
   // -----------------------------------------------
   wire logic err_ev = parity_err & iso_t0; // RULE11
   wire logic below = cnt_q < max_it;
   wire logic [2:0] cnt_inc = 3'(cnt_q + 3'h1);
   wire logic nack_d = err_ev & ~nack_inh & // RULE7
                       (~succ_dis | below); // RULE8 RULE9
   wire logic iter_set = err_ev & succ_dis & // RULE10
                         (~below | cnt_inc == max_it);
   wire logic iter_clr = wr_ctrl & iso_any & // RULE20
                         pwdata[`UMC_CR_RETRY_CLR];
   wire logic iter_d = iter_set | (iter_q & ~iter_clr);
   wire logic [2:0] cnt_d =
      (iter_clr | (char_ok & iso_t0)) ? 3'h0 :
      (err_ev & succ_dis & below)     ? cnt_inc : // RULE9
                                        cnt_q;

   // -----------------------------------------------
   // Status, mask and read mux
   // -----------------------------------------------
   umc_word_t stat_word;
   always_comb
   begin
      stat_word = status_src & `UMC_IRQ_WMASK; // RULE15 RULE16
      stat_word[`UMC_ST_ITER] = iter_q;
   end

   wire umc_word_t mask_d = (mask_q | // RULE14 RULE22
      (wr_set ? pwdata & `UMC_IRQ_WMASK : '0)) &
      ~(wr_clr ? pwdata : '0); // RULE17
   wire logic irq_d = |(stat_word & mask_q); // RULE21

   wire umc_word_t rd_data =
      hit_mode ? mode_q :
      hit_view ? mask_q :               // RULE18
      hit_stat ? stat_word :
                 '0;

   assign prdata    = prdata_q;
   assign txd_pin   = txd_q;
   assign rx_serial = rxs_q;
   assign sck_out   = sck_q;
   assign sck_oe_n  = sck_oe_n_q;
   assign nack_req  = nack_q;
   assign irq       = irq_q;

   // -----------------------------------------------
   // Register file
   // -----------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_q   <= `UMC_MODE_RST;
         mask_q   <= `UMC_IMR_RST;
         prdata_q <= '0;
      end
      else
      begin
         if (wr_mode)
            mode_q <= pwdata & `UMC_MODE_WMASK;
         mask_q <= mask_d;
         if (rd_setup)
            prdata_q <= rd_data;
      end
   end

   // -----------------------------------------------
   // Pin synchroniser and filter samples
   // -----------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         sync3_q <= 1'b1;
         rxd_q   <= 1'b1;
         samp_q  <= 3'h7;
      end
      else
      begin
         sync1_q <= rxd_pin;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q)
            rxd_q <= sync3_q;
         if (sample_tick)
            samp_q <= {samp_q[1:0], rxd_q};
      end
   end

   // -----------------------------------------------
   // Line outputs and retry state
   // -----------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         txd_q      <= 1'b1;
         rxs_q      <= 1'b1;
         sck_q      <= 1'b0;
         sck_oe_n_q <= 1'b1;
         cnt_q      <= 3'h0;
         iter_q     <= 1'b0;
         nack_q     <= 1'b0;
         irq_q      <= 1'b0;
      end
      else
      begin
         txd_q      <= txd_d;
         rxs_q      <= rxs_d;
         sck_q      <= baud_clk;
         sck_oe_n_q <= ~sck_drive;
         cnt_q      <= cnt_d;
         iter_q     <= iter_d;
         nack_q     <= nack_d;
         irq_q      <= irq_d;
      end
   end

   // -----------------------------------------------
   // Assertions
   // -----------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_mode_wr;
      wr_mode ##1 1'b1;
   endsequence

   property p_echo;
      chan == UMC_CH_ECHO |=> txd_pin == $past(rx_line)
         && rx_serial == $past(rx_line);
   endproperty
   a_echo: assert property (p_echo) // RULE1
      else $error("echo routing wrong");

   property p_local;
      chan == UMC_CH_LOCAL |=> rx_serial == $past(tx_serial)
         && txd_pin;
   endproperty
   a_local: assert property (p_local) // RULE2
      else $error("local loop routing wrong");

   property p_remote;
      chan == UMC_CH_REMOTE |=> txd_pin == $past(rx_line)
         && rx_serial;
   endproperty
   a_remote: assert property (p_remote) // RULE3
      else $error("remote loop routing wrong");

   property p_order;
      wr_mode |=> msb_first == $past(pwdata[16]);
   endproperty
   a_order: assert property (p_order) // RULE4
      else $error("bit order not applied");

   property p_nine;
      wr_mode && pwdata[17] |=> char_bits == 4'h9;
   endproperty
   a_nine: assert property (p_nine) // RULE5
      else $error("nine-bit length not applied");

   property p_sck;
      s_mode_wr |=> sck_oe_n == !($past(pwdata[18], 2)
         && $past(pwdata[5:4], 2) != 2'h3);
   endproperty
   a_sck: assert property (p_sck) // RULE6
      else $error("clock pin enable wrong");

   property p_nack_inh;
      nack_inh |=> !nack_req;
   endproperty
   a_nack_inh: assert property (p_nack_inh) // RULE7
      else $error("NACK sent while inhibited");

   property p_nack_now;
      err_ev && !nack_inh && !succ_dis |=> nack_req;
   endproperty
   a_nack_now: assert property (p_nack_now) // RULE8
      else $error("NACK missing on parity error");

   property p_iter_stop;
      err_ev && succ_dis && cnt_q >= max_it
         |=> !nack_req && iter_q;
   endproperty
   a_iter_stop: assert property (p_iter_stop) // RULE10
      else $error("retry limit not honoured");

   property p_not_t0;
      !iso_t0 |=> !nack_req;
   endproperty
   a_not_t0: assert property (p_not_t0) // RULE11
      else $error("NACK outside T0 mode");

   property p_nofilt;
      !filter_on |-> rx_line == rxd_q;
   endproperty
   a_nofilt: assert property (p_nofilt) // RULE13
      else $error("line filtered while off");

   property p_ien;
      wr_set |=> (mask_q & $past(pwdata & `UMC_IRQ_WMASK))
         == $past(pwdata & `UMC_IRQ_WMASK);
   endproperty
   a_ien: assert property (p_ien) // RULE14
      else $error("enable write not applied");

   property p_idis;
      wr_clr |=> (mask_q & $past(pwdata)) == '0;
   endproperty
   a_idis: assert property (p_idis) // RULE17
      else $error("disable write not applied");

   property p_view;
      rd_setup && hit_view |=> prdata == $past(mask_q);
   endproperty
   a_view: assert property (p_view) // RULE18
      else $error("mask view wrong");

   property p_iter_clr;
      iter_clr && !iter_set |=> !iter_q;
   endproperty
   a_iter_clr: assert property (p_iter_clr) // RULE20
      else $error("retry flag not cleared");

   property p_irq;
      (stat_word & mask_q) != '0 |=> irq;
   endproperty
   a_irq: assert property (p_irq) // RULE21
      else $error("interrupt not raised");

endmodule

/* File: tb/umc_line_peer.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Serial line peer: idles at line_lvl, can pull
// the line low for a commanded stretch
// ----------------------------------------
module umc_line_peer
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Commands from the bench
   input  wire logic       line_lvl,
   input  wire logic       go,
   input  wire logic [3:0] low_len,
   // Line
   output      logic       rxd_pin
);
   logic [3:0] cnt_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= 4'h0;
      else if (go)
         cnt_q <= low_len;
      else if (cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
   end
   // Idle level follows line_lvl from the bench, which starts high
   assign rxd_pin = (cnt_q != 4'h0) ? 1'b0 : line_lvl;
endmodule

/* File: tb/umc_top_bench.sv */
`timescale 1ns/1ps
`include "umc_map.svh"
module umc_top_bench;
   import umc_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   umc_word_t   pwdata = '0, prdata, status_src = '0;
   logic        pready, pslverr, rxd_pin, txd_pin, sck_out, sck_oe_n;
   logic        tx_serial = 1, rx_serial, sample_tick = 0, baud_clk = 0;
   logic        parity_err = 0, char_ok = 0, nack_req, msb_first, irq;
   logic [3:0]  char_bits, usart_mode, low_len = '0, tick_cnt = '0;
   logic        line_lvl = 1, go = 0;
   int          bad_count = 0, n_checks = 0;
   localparam logic [3:0] lv = 4'b0100, tv = 4'b1011;
   localparam logic [3:0] et = 4'b0101, er = 4'b1000;
   localparam logic [2:0] fsel = 3'b110, fexp = 3'b010;

   always #5 pclk = ~pclk;
   // Sample enable once every four clocks
   always @(posedge pclk)
   begin
      tick_cnt <= tick_cnt + 4'h1;
      sample_tick <= (tick_cnt[1:0] == 2'h3);
   end

   umc_top umc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rxd_pin, .txd_pin,
      .sck_in(1'b0), .sck_out, .sck_oe_n, .tx_serial, .rx_serial,
      .sample_tick, .baud_clk, .parity_err, .char_ok, .nack_req,
      .msb_first, .char_bits, .usart_mode, .status_src, .irq);
   umc_line_peer umc_line_peer_i (.pclk, .presetn, .line_lvl, .go,
      .low_len, .rxd_pin);

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic end_sim;
      $display("checks=%0d errors=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input umc_word_t d, output umc_word_t r,
                      output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         bad_count++;
         end_sim();
      end
   endtask

   task automatic wr(input logic [11:0] a, input umc_word_t d);
      umc_word_t r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd_chk(input logic [11:0] a, input umc_word_t exp);
      umc_word_t r;
      logic e;
      apb(1'b0, a, '0, r, e);
      chk(r, exp);
   endtask

   task automatic perr(input int k, input int exp);
      int n;
      n = 0;
      repeat (k)
      begin
         @(posedge pclk);
         parity_err <= 1'b1;
         repeat (4)
         begin
            @(posedge pclk);
            parity_err <= 1'b0;
            #1;
            n += int'(nack_req === 1'b1);
         end
      end
      chk(n, exp);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_mask;
      umc_word_t r;
      logic e;
      rd_chk(`UMC_OFF_IEN_VIEW, `UMC_IMR_RST);
      wr(`UMC_OFF_IEN_SET, 32'hFFFF_FFFF);
      rd_chk(`UMC_OFF_IEN_VIEW, 32'h000F_3FFF);
      wr(`UMC_OFF_IEN_CLR, 32'h0000_4001);
      rd_chk(`UMC_OFF_IEN_VIEW, 32'h000F_3FFE);
      wr(`UMC_OFF_IEN_SET, 32'h0);
      rd_chk(`UMC_OFF_IEN_VIEW, 32'h000F_3FFE);
      wr(`UMC_OFF_IEN_CLR, 32'hFFFF_FFFF);
      wr(`UMC_OFF_IEN_SET, 32'h0000_0080);
      rd_chk(`UMC_OFF_IEN_VIEW, 32'h0000_0080);
      rd_chk(`UMC_OFF_IEN_SET, 32'h0);
      apb(1'b0, 12'h020, '0, r, e);
      chk({31'h0, e}, 32'h1);
   endtask

   task automatic t_irq;
      @(posedge pclk);
      status_src <= 32'h0000_0100;
      cyc(4);
      chk({31'h0, irq}, 32'h0);
      @(posedge pclk);
      status_src <= 32'h0000_0180;
      cyc(4);
      chk({31'h0, irq}, 32'h1);
      wr(`UMC_OFF_IEN_CLR, 32'h0000_0080);
      cyc(4);
      chk({31'h0, irq}, 32'h0);
      @(posedge pclk);
      status_src <= 32'h0;
   endtask

   task automatic t_mode;
      rd_chk(`UMC_OFF_MODE, `UMC_MODE_RST);
      wr(`UMC_OFF_MODE, 32'hFFFF_FFFF);
      rd_chk(`UMC_OFF_MODE, `UMC_MODE_WMASK);
      wr(`UMC_OFF_MODE, 32'h0003_0080);
      cyc(2);
      chk({27'h0, msb_first, char_bits}, 32'h19);
      wr(`UMC_OFF_MODE, 32'h0000_0080);
      cyc(2);
      chk({27'h0, msb_first, char_bits}, 32'h07);
      wr(`UMC_OFF_MODE, 32'h0004_0000);
      baud_clk <= 1'b1;
      cyc(3);
      chk({30'h0, sck_oe_n, sck_out}, 32'h1);
      wr(`UMC_OFF_MODE, 32'h0004_0030);
      cyc(3);
      chk({31'h0, sck_oe_n}, 32'h1);
      wr(`UMC_OFF_MODE, 32'h0);
      cyc(3);
      chk({31'h0, sck_oe_n}, 32'h1);
   endtask

   task automatic t_chan;
      logic [31:0] got;
      for (int c = 0; c < 4; c++)
      begin
         wr(`UMC_OFF_MODE, {16'h0, c[1:0], 14'h0});
         @(posedge pclk);
         line_lvl <= lv[c];
         tx_serial <= tv[c];
         cyc(10);
         got = {30'h0, txd_pin, rx_serial};
         chk(got, {30'h0, et[c], er[c]});
      end
      @(posedge pclk);
      line_lvl <= 1'b1;
      tx_serial <= 1'b1;
   endtask

   task automatic t_filter;
      logic seen;
      for (int i = 0; i < 3; i++)
      begin
         wr(`UMC_OFF_MODE, {3'h0, fsel[i], 28'h0});
         repeat (8) @(posedge pclk);
         go <= 1'b1;
         low_len <= (i == 2) ? 4'hF : 4'h2;
         @(posedge pclk);
         go <= 1'b0;
         seen = 1'b1;
         repeat (24)
         begin
            cyc(1);
            seen &= rx_serial;
         end
         chk({31'h0, seen}, {31'h0, fexp[i]});
      end
   endtask

   task automatic t_nack;
      wr(`UMC_OFF_MODE, 32'h0000_0004);
      cyc(2);
      chk({28'h0, usart_mode}, 32'h4);
      perr(2, 2);
      wr(`UMC_OFF_MODE, 32'h0010_0004);
      perr(2, 0);
      @(posedge pclk);
      char_ok <= 1'b1;
      @(posedge pclk);
      char_ok <= 1'b0;
      wr(`UMC_OFF_MODE, 32'h0220_0004);
      perr(3, 2);
      rd_chk(`UMC_OFF_STATUS, 32'h0000_0400);
      wr(`UMC_OFF_MODE, 32'h0220_0000);
      wr(`UMC_OFF_CTRL, 32'h0000_2000);
      rd_chk(`UMC_OFF_STATUS, 32'h0000_0400);
      perr(2, 0);
      wr(`UMC_OFF_MODE, 32'h0220_0006);
      perr(2, 0);
      wr(`UMC_OFF_MODE, 32'h0220_0004);
      wr(`UMC_OFF_CTRL, 32'h0000_2000);
      rd_chk(`UMC_OFF_STATUS, 32'h0);
   endtask

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      cyc(1);
      t_mask();
      t_irq();
      t_mode();
      t_chan();
      t_filter();
      t_nack();
      end_sim();
   end
endmodule
